/* File: verilog/icca_ctrl.sv */
`timescale 1ns/10ps
// How it works
// - Store holds five words per stage, four stages, three filter groups.
// - Store resets to subwoofer stage-0 values, scale 80000h, redirection C0000h, LFE 80000h.
// - Filter taps rebuild b0, b1 and a1 from their offset or halved forms.
// - Every coefficient word is a 20-bit two's-complement fraction.
// - Input scale gain is the negated stored scale word.
// - Subwoofer redirection gain per channel is the negated stored factor.
// - Each 16-bit register is upper byte at even, lower byte at odd address.
// - Device is target only: never drives clock, only pulls data low.
// - Data falling with clock high is START, rising is STOP.
// - Data is sampled on each rising serial clock edge.
// - Receiver pulls data low in the ninth clock to acknowledge.
// - Address byte LSB one means read, zero means write.
// - Byte after a write address is the internal byte address, acknowledged.
// - Every written data byte is acknowledged; runs end with STOP.
// - Any write to the reset register restores control registers to defaults.
// - Reading the reset register returns a fixed identification code.
// - Store access starts only when the control word low byte is written.
// - Control word: address in upper byte, top data bits in lowest nibble.
module icca_ctrl #(
  parameter logic [15:0] ID_CODE = 16'h5A31 // Arbitrary identification value.
) (
  // System clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Two-wire serial link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic address_select_pin_i,
  // Coefficient taps for the filter datapath
  input wire logic [1:0] tap_group_i,
  input wire logic [1:0] tap_stage_i,
  input wire logic [2:0] redir_chan_i,
  output icca_pkg::icca_tap_type tap_o,
  output logic [20:0] redir_gain_o
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  icca_pkg::icca_link_type lk_ff;
  icca_pkg::icca_link_type nxt_lk;
  icca_pkg::icca_sys_type sy_ff;
  icca_pkg::icca_sys_type nxt_sy;
  // Frame-limit toggles live in the data line's own edge domain.
  // The link domain compares them against its own copies, so no
  // frame limit can be lost even when it falls between clock edges.
  logic start_tgl_ff;
  logic stop_tgl_ff;
  logic drive_ff;
  // One word per coefficient of the store.
  // The taps read several words at once, so the array is built from
  // flip-flops; a single-port memory could not feed them in one cycle.
  logic [19:0] store_mem [0:68];
  logic start_evt;
  logic stop_evt;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic [7:0] tx_load;
  // Write strobe and word index of the store access in flight.
  // Both belong to the system clock domain only.
  logic st_we;
  logic [7:0] st_idx;
  logic [7:0] tap_base;
  logic [7:0] scale_idx;
  logic [7:0] redir_idx;

  // ******************************************************************
  // Bus condition detectors
  // ******************************************************************

  // Data edges with the clock high mark the frame limits; the toggles are
  // only compared at the next rising clock, which by then is long settled.
  always_ff @(negedge sda_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      start_tgl_ff <= 1'b0;
    end else if (scl_i) begin
      start_tgl_ff <= ~start_tgl_ff;
    end
  end

  always_ff @(posedge sda_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stop_tgl_ff <= 1'b0;
    end else if (scl_i) begin
      stop_tgl_ff <= ~stop_tgl_ff;
    end
  end

  // The pull-down changes only while the clock is low.
  // Updating on the falling clock leaves the whole low phase for settling,
  // so the master always samples a stable level at the rising edge.
  always_ff @(negedge scl_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= lk_ff.drive;
    end
  end

  // Open-drain: the line is only ever pulled low, the clock never driven.
  // Driving a high level could fight the master, so the value stays zero.
  assign sda_o = 1'b0;
  assign sda_oe_o = drive_ff;

  // ******************************************************************
  // Register byte read map
  // ******************************************************************

  // Unmapped byte addresses read as zero.
  // The identification pair is a parameter, so every variant of the part
  // shares this logic and only the instance value differs.
  always_comb begin
    case (lk_ff.byte_addr)
      icca_pkg::ICCA_ADR_RESET_HI: rd_byte = ID_CODE[15:8];
      icca_pkg::ICCA_ADR_RESET_LO: rd_byte = ID_CODE[7:0];
      icca_pkg::ICCA_ADR_DATA_HI: rd_byte = lk_ff.data_low[15:8];
      icca_pkg::ICCA_ADR_DATA_LO: rd_byte = lk_ff.data_low[7:0];
      icca_pkg::ICCA_ADR_CTRL_HI: rd_byte = lk_ff.ctrl[15:8];
      icca_pkg::ICCA_ADR_CTRL_LO: rd_byte = lk_ff.ctrl[7:0];
      default: rd_byte = 8'h00;
    endcase
  end

  // ******************************************************************
  // Link domain, clocked by the serial clock
  // ******************************************************************

  // Byte engine: bit_cnt 0..7 are data bits, 8 is the acknowledge slot.
  always_comb begin
    nxt_lk = lk_ff;
    start_evt = (start_tgl_ff != lk_ff.start_seen);
    stop_evt = (stop_tgl_ff != lk_ff.stop_seen);
    rx_byte = {lk_ff.shift[6:0], sda_i};
    tx_load = rd_byte;
    nxt_lk.start_seen = start_tgl_ff;
    nxt_lk.stop_seen = stop_tgl_ff;
    nxt_lk.ack_s1 = sy_ff.ack_tgl;
    nxt_lk.ack_s2 = lk_ff.ack_s1;
    nxt_lk.sa_s1 = address_select_pin_i;
    nxt_lk.sa_s2 = lk_ff.sa_s1;
    // The pull-down is decided afresh at every rising clock and released
    // unless asked for, so a cut frame never leaves the line held low.
    nxt_lk.drive = 1'b0;
    // A finished store read lands in the data registers.
    // When a new read is launched in the same edge, its later assignment
    // keeps the wait flag set, so the set wins over the clear.
    if (lk_ff.ack_s2 != lk_ff.ack_seen) begin
      nxt_lk.ack_seen = lk_ff.ack_s2;
      if (lk_ff.rd_wait) begin
        nxt_lk.data_low = sy_ff.result[15:0];
        nxt_lk.ctrl[3:0] = sy_ff.result[19:16];
        nxt_lk.rd_wait = 1'b0;
      end
    end
    if (start_evt) begin
      // A START (also a repeated one) restarts address reception.
      nxt_lk.phase = icca_pkg::ICCA_ADDR;
      nxt_lk.shift = rx_byte;
      nxt_lk.bit_cnt = 4'h1;
    end else if (stop_evt) begin
      nxt_lk.phase = icca_pkg::ICCA_IDLE;
      nxt_lk.bit_cnt = 4'h0;
    end else begin
      case (lk_ff.phase)
        icca_pkg::ICCA_IDLE: begin
          nxt_lk.bit_cnt = 4'h0;
        end
        icca_pkg::ICCA_ADDR, icca_pkg::ICCA_REG, icca_pkg::ICCA_WDATA: begin
          if (lk_ff.bit_cnt == icca_pkg::ICCA_ACK_SLOT) begin
            nxt_lk.bit_cnt = 4'h0;
          end else begin
            nxt_lk.shift = rx_byte;
            nxt_lk.bit_cnt = lk_ff.bit_cnt + 4'h1;
            if (lk_ff.bit_cnt == icca_pkg::ICCA_LAST_BIT) begin
              case (lk_ff.phase)
                icca_pkg::ICCA_ADDR: begin
                  if (rx_byte[7:1] == {icca_pkg::ICCA_DEV_ADDR_HI, lk_ff.sa_s2}) begin
                    nxt_lk.drive = 1'b1;
                    nxt_lk.rd_fresh = 1'b1;
                    nxt_lk.phase = rx_byte[0] ? icca_pkg::ICCA_RDATA : icca_pkg::ICCA_REG;
                  end else begin
                    // A foreign address sends us idle; we keep off the line
                    // until the next START, whatever else the frame carries.
                    nxt_lk.phase = icca_pkg::ICCA_IDLE;
                  end
                end
                icca_pkg::ICCA_REG: begin
                  nxt_lk.byte_addr = rx_byte;
                  nxt_lk.drive = 1'b1;
                  nxt_lk.phase = icca_pkg::ICCA_WDATA;
                end
                default: begin
                  nxt_lk.drive = 1'b1;
                  nxt_lk.byte_addr = lk_ff.byte_addr + 8'h01;
                  case (lk_ff.byte_addr)
                    icca_pkg::ICCA_ADR_RESET_HI, icca_pkg::ICCA_ADR_RESET_LO: begin
                      nxt_lk.data_low = icca_pkg::ICCA_DATA_RST;
                      nxt_lk.ctrl = icca_pkg::ICCA_CTRL_RST;
                    end
                    icca_pkg::ICCA_ADR_DATA_HI: nxt_lk.data_low[15:8] = rx_byte;
                    icca_pkg::ICCA_ADR_DATA_LO: nxt_lk.data_low[7:0] = rx_byte;
                    icca_pkg::ICCA_ADR_CTRL_HI: nxt_lk.ctrl[15:8] = rx_byte;
                    icca_pkg::ICCA_ADR_CTRL_LO: begin
                      // Writing this byte fires the store access.
                      nxt_lk.ctrl[7:0] = rx_byte;
                      nxt_lk.req_addr = lk_ff.ctrl[15:8];
                      nxt_lk.req_rw = rx_byte[icca_pkg::ICCA_CTRL_RW_BIT];
                      nxt_lk.req_data = {rx_byte[3:0], lk_ff.data_low};
                      nxt_lk.rd_wait = rx_byte[icca_pkg::ICCA_CTRL_RW_BIT];
                      nxt_lk.req_tgl = ~lk_ff.req_tgl;
                    end
                    default: ;
                  endcase
                end
              endcase
            end
          end
        end
        icca_pkg::ICCA_RDATA: begin
          if (lk_ff.bit_cnt == icca_pkg::ICCA_ACK_SLOT) begin
            // After the address ack, or a master ack, send the next byte.
            if (lk_ff.rd_fresh || !sda_i) begin
              nxt_lk.tx = tx_load;
              nxt_lk.drive = ~tx_load[7];
              nxt_lk.byte_addr = lk_ff.byte_addr + 8'h01;
              nxt_lk.rd_fresh = 1'b0;
              nxt_lk.bit_cnt = 4'h0;
            end else begin
              // A not-acknowledge ends the read; the line stays released
              // so the master is free to send its STOP.
              nxt_lk.phase = icca_pkg::ICCA_IDLE;
              nxt_lk.bit_cnt = 4'h0;
            end
          end else begin
            nxt_lk.bit_cnt = lk_ff.bit_cnt + 4'h1;
            nxt_lk.tx = {lk_ff.tx[6:0], 1'b0};
            // Release after the eighth bit so the master can answer.
            nxt_lk.drive = (lk_ff.bit_cnt != icca_pkg::ICCA_LAST_BIT) && !lk_ff.tx[6];
          end
        end
        default: begin
          nxt_lk.phase = icca_pkg::ICCA_IDLE;
        end
      endcase
    end
  end

  // Link state register.
  // It runs only while the master clocks the bus; a STOP is therefore
  // only seen at the first rising clock of the following frame, where that frame's START wins over it.
  always_ff @(posedge scl_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lk_ff <= '0;
      lk_ff.data_low <= icca_pkg::ICCA_DATA_RST;
      lk_ff.ctrl <= icca_pkg::ICCA_CTRL_RST;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  // ******************************************************************
  // System domain: coefficient store and taps
  // ******************************************************************

  // The request payload is held still by the link while the toggle travels,
  // so only the toggle needs the two-stage synchroniser.
  // An index outside the store is acknowledged back and otherwise dropped,
  // so the link never waits for an answer that cannot come.
  always_comb begin
    nxt_sy = sy_ff;
    nxt_sy.req_s1 = lk_ff.req_tgl;
    nxt_sy.req_s2 = sy_ff.req_s1;
    st_idx = lk_ff.req_addr - icca_pkg::ICCA_COEF_BASE;
    st_we = 1'b0;
    if (sy_ff.req_s2 != sy_ff.req_seen) begin
      nxt_sy.req_seen = sy_ff.req_s2;
      nxt_sy.ack_tgl = ~sy_ff.ack_tgl;
      if (lk_ff.req_addr >= icca_pkg::ICCA_COEF_BASE && st_idx < icca_pkg::ICCA_COEF_COUNT) begin
        if (lk_ff.req_rw) begin
          nxt_sy.result = store_mem[st_idx[6:0]];
        end else begin
          st_we = 1'b1;
        end
      end
    end
    // Stage words sit in the order b2, b0-1, a2, a1/2, b1/2.
    tap_base = 8'(tap_group_i * icca_pkg::ICCA_GROUP_COEFS) + 8'(tap_stage_i * icca_pkg::ICCA_STAGE_COEFS);
    scale_idx = icca_pkg::ICCA_SCALE_BASE + {6'h00, tap_group_i};
    redir_idx = icca_pkg::ICCA_REDIR_BASE + {5'h00, redir_chan_i};
    nxt_sy.tap = '0;
    if (tap_group_i < icca_pkg::ICCA_GROUPS) begin
      nxt_sy.tap.b2 = {store_mem[tap_base[6:0]][19], store_mem[tap_base[6:0]]};
      nxt_sy.tap.b0 = 21'({store_mem[tap_base[6:0] + 7'h01][19], store_mem[tap_base[6:0] + 7'h01]}
        + icca_pkg::ICCA_UNITY);
      nxt_sy.tap.a2 = {store_mem[tap_base[6:0] + 7'h02][19], store_mem[tap_base[6:0] + 7'h02]};
      nxt_sy.tap.a1 = {store_mem[tap_base[6:0] + 7'h03], 1'b0};
      nxt_sy.tap.b1 = {store_mem[tap_base[6:0] + 7'h04], 1'b0};
      nxt_sy.tap.scale = 21'(-{store_mem[scale_idx[6:0]][19], store_mem[scale_idx[6:0]]});
    end
    nxt_sy.redir = '0;
    if (redir_chan_i < icca_pkg::ICCA_REDIR_CHANS) begin
      nxt_sy.redir = 21'(-{store_mem[redir_idx[6:0]][19], store_mem[redir_idx[6:0]]});
    end
  end

  // System state register.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sy_ff <= '0;
    end else begin
      sy_ff <= nxt_sy;
    end
  end

  // Store array; reset loads the default coefficient set.
  // Only the hardware reset reloads it; the register soft reset leaves
  // the coefficients alone, so a tuned filter survives a control reset.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < int'(icca_pkg::ICCA_COEF_COUNT); i++) begin
        store_mem[i] <= icca_pkg::icca_coef_default(8'(i));
      end
    end else if (st_we) begin
      store_mem[st_idx[6:0]] <= lk_ff.req_data;
    end
  end

  // Taps and the redirection gain come straight from registers,
  // one system clock after their selection inputs.
  assign tap_o = sy_ff.tap;
  assign redir_gain_o = sy_ff.redir;

endmodule // icca_ctrl

/* File: verilog/icca_pkg.sv */
package icca_pkg;

  // ******************************************************************
  // Serial control map, byte addresses
  // ******************************************************************
  localparam logic [7:0] ICCA_ADR_RESET_HI = 8'h00;
  localparam logic [7:0] ICCA_ADR_RESET_LO = 8'h01;
  localparam logic [7:0] ICCA_ADR_DATA_HI = 8'h78;
  localparam logic [7:0] ICCA_ADR_DATA_LO = 8'h79;
  localparam logic [7:0] ICCA_ADR_CTRL_HI = 8'h7A;
  localparam logic [7:0] ICCA_ADR_CTRL_LO = 8'h7B;
  localparam logic [15:0] ICCA_DATA_RST = 16'h0000;
  localparam logic [15:0] ICCA_CTRL_RST = 16'h0000;
  localparam int ICCA_CTRL_RW_BIT = 4;
  localparam logic [5:0] ICCA_DEV_ADDR_HI = 6'h0F;
  localparam logic [3:0] ICCA_LAST_BIT = 4'h7;
  localparam logic [3:0] ICCA_ACK_SLOT = 4'h8;

  // ******************************************************************
  // Coefficient store layout and defaults
  // ******************************************************************
  localparam int ICCA_COEF_W = 20;
  localparam logic [7:0] ICCA_COEF_BASE = 8'h40;
  localparam logic [7:0] ICCA_COEF_COUNT = 8'h45;
  localparam logic [7:0] ICCA_GROUP_COEFS = 8'h14;
  localparam logic [7:0] ICCA_STAGE_COEFS = 8'h05;
  localparam logic [7:0] ICCA_SBW_BASE = 8'h28;
  localparam logic [7:0] ICCA_SCALE_BASE = 8'h3C;
  localparam logic [7:0] ICCA_REDIR_BASE = 8'h3F;
  localparam logic [7:0] ICCA_REDIR_LFE = 8'h44;
  localparam logic [1:0] ICCA_GROUPS = 2'h3;
  localparam logic [2:0] ICCA_REDIR_CHANS = 3'h6;
  localparam logic [20:0] ICCA_UNITY = 21'h080000;
  localparam logic [19:0] ICCA_SBW_DEF0 = 20'h00032;
  localparam logic [19:0] ICCA_SBW_DEF1 = 20'h80032;
  localparam logic [19:0] ICCA_SBW_DEF2 = 20'h7C7EA;
  localparam logic [19:0] ICCA_SBW_DEF3 = 20'h81C6F;
  localparam logic [19:0] ICCA_SBW_DEF4 = 20'h00032;
  localparam logic [19:0] ICCA_SCALE_DEF = 20'h80000;
  localparam logic [19:0] ICCA_REDIR_DEF = 20'hC0000;
  localparam logic [19:0] ICCA_REDIR_LFE_DEF = 20'h80000;

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [2:0] {
    ICCA_IDLE = 3'b000,
    ICCA_ADDR = 3'b001,
    ICCA_REG = 3'b010,
    ICCA_WDATA = 3'b011,
    ICCA_RDATA = 3'b100
  } icca_phase_type;

  typedef struct packed {
    logic [20:0] b0;
    logic [20:0] b1;
    logic [20:0] b2;
    logic [20:0] a1;
    logic [20:0] a2;
    logic [20:0] scale;
  } icca_tap_type;

  typedef struct packed {
    icca_phase_type phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] byte_addr;
    logic drive;
    logic rd_fresh;
    logic [15:0] data_low;
    logic [15:0] ctrl;
    logic req_tgl;
    logic [7:0] req_addr;
    logic req_rw;
    logic [19:0] req_data;
    logic rd_wait;
    logic start_seen;
    logic stop_seen;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic sa_s1;
    logic sa_s2;
  } icca_link_type;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    logic [19:0] result;
    icca_tap_type tap;
    logic [20:0] redir;
  } icca_sys_type;

  // Power-on content of one coefficient store word.
  function automatic logic [19:0] icca_coef_default(input logic [7:0] idx);
    logic [19:0] val;
    val = 20'h00000;
    if (idx == ICCA_SBW_BASE) val = ICCA_SBW_DEF0;
    if (idx == ICCA_SBW_BASE + 8'h01) val = ICCA_SBW_DEF1;
    if (idx == ICCA_SBW_BASE + 8'h02) val = ICCA_SBW_DEF2;
    if (idx == ICCA_SBW_BASE + 8'h03) val = ICCA_SBW_DEF3;
    if (idx == ICCA_SBW_BASE + 8'h04) val = ICCA_SBW_DEF4;
    if (idx >= ICCA_SCALE_BASE && idx < ICCA_REDIR_BASE) val = ICCA_SCALE_DEF;
    if (idx >= ICCA_REDIR_BASE && idx < ICCA_REDIR_LFE) val = ICCA_REDIR_DEF;
    if (idx == ICCA_REDIR_LFE) val = ICCA_REDIR_LFE_DEF;
    return val;
  endfunction

endpackage

/* File: dv/icca_properties.sv */
`timescale 1ns/10ps
// ****************************************
// Port checker of the control block
// ****************************************
module icca_properties (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Serial link
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic address_select_pin_i,
  // Coefficient taps
  input wire logic [1:0] tap_group_i,
  input wire logic [1:0] tap_stage_i,
  input wire logic [2:0] redir_chan_i,
  input wire icca_pkg::icca_tap_type tap_o,
  input wire logic [20:0] redir_gain_o
);
  // Tap checks lean on store defaults, so the bench never writes subwoofer stage 0 or the gain words.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_SDA_VAL: assert property (sda_o == 1'b0)
    else $error("data line value is not low");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed with clock high");
  AST_IDLE_FREE: assert property (scl_i [*8] |-> !sda_oe_o)
    else $error("data line held while bus idle");
  AST_TAP_NONE: assert property (tap_group_i == 2'h3 |=> tap_o == '0)
    else $error("unused group gives nonzero taps");
  AST_REDIR_NONE: assert property (redir_chan_i > 3'h5 |=> redir_gain_o == 21'h000000)
    else $error("unused channel gives nonzero gain");
  AST_REDIR_LFE: assert property (redir_chan_i == 3'h5 |=> redir_gain_o == 21'h080000)
    else $error("effects channel gain wrong");
  AST_REDIR_CH: assert property (redir_chan_i < 3'h5 |=> redir_gain_o == 21'h040000)
    else $error("channel redirection gain wrong");
  AST_HALVED: assert property (tap_o.b1[0] == 1'b0 && tap_o.a1[0] == 1'b0)
    else $error("halved coefficient not doubled");
  AST_SCALE: assert property (tap_group_i != 2'h3 |=> tap_o.scale == 21'h080000)
    else $error("input scale gain wrong");
  AST_SBW_STAGE0: assert property (tap_group_i == 2'h2 && tap_stage_i == 2'h0 |=>
    tap_o.b2 == 21'h000032 && tap_o.b0 == 21'h000032 && tap_o.a2 == 21'h07C7EA &&
    tap_o.a1 == 21'h1038DE && tap_o.b1 == 21'h000064)
    else $error("subwoofer stage zero taps wrong");
endmodule // icca_properties

bind icca_ctrl icca_properties u_props (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .address_select_pin_i(address_select_pin_i),
  .tap_group_i(tap_group_i), .tap_stage_i(tap_stage_i), .redir_chan_i(redir_chan_i),
  .tap_o(tap_o), .redir_gain_o(redir_gain_o));

/* File: dv/icca_master.sv */
`timescale 1ns/10ps
// ****************************************
// Two-wire bus master model
// ****************************************
module icca_master (
  // Serial link
  output logic scl_o,
  output logic sda_oe_o,
  input wire logic sda_i
);
  logic [8:0] res;
  event res_ev;
  // Clock stands high between frames and the data line is released.
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    res = 9'h000;
  end
  // Start from idle or, with the clock low, a repeated start.
  task automatic start();
    // A short pause after the clock fall keeps the data move clear of it.
    #1;
    sda_oe_o = 1'b0;
    #14;
    scl_o = 1'b1;
    #15;
    sda_oe_o = 1'b1;
    #15;
    scl_o = 1'b0;
  endtask
  // Stop ends the frame and leaves the clock standing high.
  task automatic stop();
    #1;
    sda_oe_o = 1'b1;
    #14;
    scl_o = 1'b1;
    #15;
    sda_oe_o = 1'b0;
    #15;
  endtask
  // Data only moves while the clock is low; the wire is sampled just after the rise.
  task automatic clk_bit(input logic b, output logic s);
    #1;
    sda_oe_o = !b;
    #14;
    scl_o = 1'b1;
    #1;
    s = sda_i;
    #14;
    scl_o = 1'b0;
  endtask
  // One byte slot, MSB first, then the acknowledge pulse.
  task automatic xfer(input logic [7:0] d, input logic mack);
    logic s;
    logic [7:0] r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
      r[i] = s;
    end
    clk_bit(mack, s);
    res = {s, r};
    -> res_ev;
  endtask
endmodule // icca_master

/* File: dv/tb.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
  // ****************************************
  // Bench signals
  // ****************************************
  logic ref_clk = 1'b0;
  logic reset_n;
  logic sa = 1'b0;
  logic hold = 1'b0;
  logic [1:0] grp = 2'h0;
  logic [1:0] stg = 2'h0;
  logic [2:0] chan = 3'h0;
  logic sda_o, sda_oe, scl, m_oe;
  wire sda_w;
  icca_pkg::icca_tap_type tap;
  logic [20:0] redir, got, sx;
  logic [8:0] exp_q[$];
  logic [8:0] exp_r;
  logic [7:0] dev = 8'h3C;
  logic [19:0] d;
  integer seed = 83;
  int error_cnt = 0;
  int checks_done = 0;

  always #5 ref_clk = ~ref_clk;
  // The line has a pull-up, so it is high whenever nobody pulls it.
  assign sda_w = !((sda_oe & !sda_o) | m_oe);

  icca_ctrl #(.ID_CODE(16'hC3A5)) dut (.ref_clk_i(ref_clk), .reset_n_i(reset_n), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .address_select_pin_i(sa), .tap_group_i(grp),
    .tap_stage_i(stg), .redir_chan_i(chan), .tap_o(tap), .redir_gain_o(redir));
  icca_master m (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda_w));

  // Random tap selection keeps the checker busy unless a check holds the selection.
  always @(negedge ref_clk) begin
    chan <= 3'($random(seed));
    if (!hold) begin
      {grp, stg} <= 4'($random(seed));
    end
  end

  // Every finished byte slot is matched against the oldest note.
  always @(m.res_ev) begin
    exp_r = exp_q.pop_front();
    `CHK(m.res, exp_r)
  end

  task automatic wr(input logic [7:0] b, input logic nack);
    exp_q.push_back({nack, b});
    m.xfer(b, 1'b1);
  endtask
  task automatic rd(input logic [7:0] b, input logic last);
    exp_q.push_back({last, b});
    m.xfer(8'hFF, last);
  endtask
  task automatic wframe(input logic [7:0] q[$]);
    hold = 1'b0;
    m.start();
    foreach (q[i]) wr(q[i], 1'b0);
    m.stop();
  endtask
  task automatic rframe(input logic [7:0] a, input logic [7:0] q[$]);
    m.start();
    wr(dev, 1'b0);
    wr(a, 1'b0);
    m.start();
    wr({dev[7:1], 1'b1}, 1'b0);
    foreach (q[i]) rd(q[i], i == q.size() - 1);
    m.stop();
  endtask
  // Holds a tap selection long enough for the store and the tap register to settle.
  task automatic look(input logic [1:0] g, input logic [1:0] s);
    hold = 1'b1;
    @(negedge ref_clk);
    grp <= g;
    stg <= s;
    repeat (20) @(negedge ref_clk);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    // Driven here, not at declaration, so the design sees a real falling edge.
    reset_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    rframe(8'h00, '{8'hC3, 8'hA5});
    rframe(8'h20, '{8'h00});
    m.start();
    wr(8'h3E, 1'b1);
    m.stop();
    @(negedge ref_clk);
    sa = 1'b1;
    m.start();
    wr(8'h3C, 1'b1);
    m.stop();
    dev = 8'h3E;
    $display("test addressing done");
    wframe('{dev, 8'h78, 8'h23, 8'h45, 8'h40, 8'h09});
    look(2'h0, 2'h0);
    `CHK(tap.b2, 21'h192345)
    wframe('{dev, 8'h00, 8'h5A});
    rframe(8'h78, '{8'h00, 8'h00, 8'h00, 8'h00});
    wframe('{dev, 8'h7A, 8'h40, 8'h10});
    rframe(8'h78, '{8'h23, 8'h45, 8'h40, 8'h19});
    $display("test store access done");
    for (int k = 0; k < 5; k++) begin
      d = 20'($random(seed));
      wframe('{dev, 8'h78, d[15:8], d[7:0], 8'h59 + 8'(k), {4'h0, d[19:16]}});
      look(2'h1, 2'h1);
      sx = {d[19], d};
      case (k)
        0: got = tap.b2;
        1: got = tap.b0;
        2: got = tap.a2;
        3: got = tap.a1;
        default: got = tap.b1;
      endcase
      if (k == 1) sx = sx + icca_pkg::ICCA_UNITY;
      if (k > 2) sx = sx << 1;
      `CHK(got, sx)
    end
    `CHK(tap.scale, 21'h080000)
    $display("test coefficient order done");
    summarize();
  end

  // The sequence needs about 21 us; nearly ten times that means a hang.
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
endmodule // tb
